/* design/isrs_pkg.sv */
package isrs_pkg;

  // Link word and lane geometry.
  localparam int WORD_W = 12;
  localparam int NUM_LANES = 16;
  localparam int PIX_DIV = 12;

  // Register offsets on the configuration port.
  localparam logic [6:0] REG_EXPOSURE_COUNT = 7'h20;
  localparam logic [6:0] REG_EXPOSURE_SOURCE = 7'h51;
  localparam logic [6:0] REG_OVERHEAD_MULT = 7'h52;
  localparam logic [6:0] REG_SYNTH_IMAGE = 7'h53;
  localparam logic [6:0] REG_ALIGNMENT_WORD = 7'h5a;
  localparam logic [6:0] REG_DEBUG_ONE_SEL = 7'h5c;
  localparam logic [6:0] REG_DEBUG_TWO_SEL = 7'h62;

  // Values after reset.
  localparam logic [15:0] RST_EXPOSURE_COUNT = 16'h0f00;
  localparam logic RST_EXPOSURE_SOURCE = 1'b0;
  localparam logic [7:0] RST_OVERHEAD_MULT = 8'h50;
  localparam logic RST_SYNTH_IMAGE = 1'b0;
  localparam logic [11:0] RST_ALIGNMENT_WORD = 12'h000;
  localparam logic [3:0] RST_DEBUG_ONE_SEL = 4'h0;
  localparam logic [2:0] RST_DEBUG_TWO_SEL = 3'h0;

  // Timing figures, counted in pixel clock periods.
  localparam int ROW_PERIOD = 641;
  localparam int BURST_LEN = 640;
  localparam int EXP_OVH_FACTOR = 47;
  localparam int OVH_MULT_FACTOR = 80;
  localparam int OVH_MULT_DIV = 8;
  localparam int OVH_ROWS = 2;

  // Debug select codes.
  localparam logic [2:0] DBG2_ROW_VALID = 3'h0;
  localparam logic [2:0] DBG2_INTEG_ONE = 3'h3;
  localparam logic [2:0] DBG2_PIX_CLOCK = 3'h7;
  localparam logic [3:0] DBG1_FRAME_VALID = 4'h0;
  localparam logic [3:0] DBG1_OVERHEAD = 4'h2;
  localparam logic [3:0] DBG1_INTEG_TWO = 4'h3;

  // Control lane status word, bit 11 down to bit 0.
  typedef struct packed {
    logic [1:0] zero_hi;
    logic one9;
    logic zero8;
    logic integ_two;
    logic integ_one;
    logic overhead;
    logic [1:0] zero_mid;
    logic frame_valid;
    logic row_valid;
    logic pixel_valid;
  } isrs_status_t;

  typedef enum logic [1:0] {RD_IDLE = 2'h0, RD_OVERHEAD = 2'h1, RD_READOUT = 2'h3} isrs_rd_t;
  typedef enum logic [1:0] {EX_IDLE = 2'h0, EX_RUN = 2'h1, EX_PEND = 2'h3} isrs_ex_t;

endpackage

/* design/isrs_pix_div.sv */
`timescale 1ns/10ps
// Makes the pixel rate enable, the forwarded bit clock and the slow debug clock.
module isrs_pix_div
  import isrs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  output logic o_pix_en,
  output logic o_ddr_clk,
  output logic o_slow_clk
);

  logic [3:0] cnt_q;

  // The enable fires on the last bit slot so a new word starts next cycle.
  assign o_pix_en = (cnt_q == 4'(PIX_DIV - 1));

  // Bit slot counter.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= o_pix_en ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // Forwarded clock is high during even bits, so bit 0 goes out in the high phase.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ddr_clk <= 1'b0;
      o_slow_clk <= 1'b0;
    end else begin
      o_ddr_clk <= o_pix_en ? 1'b1 : ~o_ddr_clk;
      o_slow_clk <= (cnt_q == 4'(PIX_DIV - 1)) || (cnt_q < 4'(PIX_DIV / 2 - 1));
    end
  end

endmodule

/* design/isrs_serializer.sv */
`timescale 1ns/10ps
// Shifts one word out per pixel period, least significant bit first.
module isrs_serializer
  import isrs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_load,
  input wire logic [WORD_W-1:0] i_word,
  output logic o_bit
);

  logic [WORD_W-1:0] sh_q;

  // Load on the pixel enable, then shift right each bit slot.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sh_q <= '0;
    end else if (i_load) begin
      sh_q <= i_word;
    end else begin
      sh_q <= {1'b0, sh_q[WORD_W-1:1]};
    end
  end

  assign o_bit = sh_q[0];

endmodule

/* design/isrs_readout.sv */
`timescale 1ns/10ps
// Summary of operation
// - Control lane word bit 0 pixel valid, bit 1 row valid, bit 2 frame valid.
// - Bits 3,4,8,10,11 are zero, bit 9 one; idle word is only bit 9.
// - Bit 5 is high during the frame overhead period.
// - Bit 6 and bit 7 are high while the two integration blocks integrate.
// - Control lane always carries status words, never the training word.
// - All 16 data lanes send the training word whenever no pixel is valid.
// - The 12-bit training word comes from the writable register at address 90.
// - With register 83 bit 0 set, a frame request yields a synthetic image.
// - Synthetic pixel equals row number plus pixel number plus lane index.
// - Register 81 bit 0 picks internal count (0, default) or pin-timed exposure.
// - External exposure runs from start-pin rising edge to request-pin rising edge.
// - Internal exposure lasts (count-1)*641+1+47*multiplier pixel periods; count minimum one.
// - The pixel period is twelve periods of the input clock.
// - Overhead lasts 80*mult + mult/8 + 2*641 pixel periods.
// - Readout lasts 641 pixel periods per row pair, lines divided by sides.
// - Frame is overhead plus readout; next exposure overlaps the current readout.
// - Debug pins show selected row/frame valid, overhead, integration or slow clock.
// - Bursts of 640 pixels per lane, separated by a one-period gap.
// - Words leave LSB first, bit 0 during the forwarded clock high phase.
module isrs_readout
  import isrs_pkg::*;
#(
  parameter int NUM_LINES = 3840,
  parameter int NUM_SIDES = 2
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [6:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_frame_req_pin,
  input wire logic i_exposure_start_pin,
  input wire logic [NUM_LANES*WORD_W-1:0] i_pixel_data,
  output logic [NUM_LANES-1:0] o_data_lanes,
  output logic o_control_lane,
  output logic o_lvds_clk,
  output logic o_debug_pin_one,
  output logic o_debug_pin_two
);

  localparam int BURSTS = NUM_LINES / NUM_SIDES;

  // Refuse geometries the burst counter cannot represent.
  if (NUM_SIDES < 1 || NUM_SIDES > 2 || NUM_LINES < NUM_SIDES ||
      (NUM_LINES % NUM_SIDES) != 0 || BURSTS > 65535) begin : g_bad_geometry
    $error("isrs_readout: unsupported line or side count");
  end

  logic [15:0] exp_count_q;
  logic exp_source_q;
  logic [7:0] ovh_mult_q;
  logic synth_q;
  logic [11:0] align_q;
  logic [3:0] dbg1_sel_q;
  logic [2:0] dbg2_sel_q;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic [2:0] req_sync_q;
  logic [2:0] start_sync_q;
  logic req_evt_q;
  logic start_evt_q;
  isrs_rd_t rd_q;
  isrs_ex_t ex_q;
  logic [31:0] rd_cnt_q;
  logic [31:0] ex_cnt_q;
  logic [9:0] pix_q;
  logic [15:0] burst_q;
  logic dbg1_q;
  logic dbg2_q;
  logic pix_en;
  logic slow_clk;
  logic [31:0] exp_len;
  logic [31:0] ovh_len;
  logic rd_free;
  logic exp_end;
  logic start_ovh;
  logic last_pix;
  isrs_status_t status;
  logic [NUM_LANES*WORD_W-1:0] lane_words;

  // Divider: twelve input clocks per pixel period and the forwarded bit clock.
  isrs_pix_div u_div (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .o_pix_en(pix_en),
    .o_ddr_clk(o_lvds_clk),
    .o_slow_clk(slow_clk)
  );

  // Register writes from the configuration port.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      exp_count_q <= RST_EXPOSURE_COUNT;
      exp_source_q <= RST_EXPOSURE_SOURCE;
      ovh_mult_q <= RST_OVERHEAD_MULT;
      synth_q <= RST_SYNTH_IMAGE;
      align_q <= RST_ALIGNMENT_WORD;
      dbg1_sel_q <= RST_DEBUG_ONE_SEL;
      dbg2_sel_q <= RST_DEBUG_TWO_SEL;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        REG_EXPOSURE_COUNT: exp_count_q <= i_reg_wdata;
        REG_EXPOSURE_SOURCE: exp_source_q <= i_reg_wdata[0];
        REG_OVERHEAD_MULT: ovh_mult_q <= i_reg_wdata[7:0];
        REG_SYNTH_IMAGE: synth_q <= i_reg_wdata[0];
        REG_ALIGNMENT_WORD: align_q <= i_reg_wdata[11:0];
        REG_DEBUG_ONE_SEL: dbg1_sel_q <= i_reg_wdata[3:0];
        REG_DEBUG_TWO_SEL: dbg2_sel_q <= i_reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // Register reads answer one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_reg_rd;
      if (i_reg_rd) begin
        unique case (i_reg_addr)
          REG_EXPOSURE_COUNT: rdata_q <= exp_count_q;
          REG_EXPOSURE_SOURCE: rdata_q <= {15'h0000, exp_source_q};
          REG_OVERHEAD_MULT: rdata_q <= {8'h00, ovh_mult_q};
          REG_SYNTH_IMAGE: rdata_q <= {15'h0000, synth_q};
          REG_ALIGNMENT_WORD: rdata_q <= {4'h0, align_q};
          REG_DEBUG_ONE_SEL: rdata_q <= {12'h000, dbg1_sel_q};
          REG_DEBUG_TWO_SEL: rdata_q <= {13'h0000, dbg2_sel_q};
          default: rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;

  // Pin synchronisers; only the second and third stages feed edge detection.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      req_sync_q <= 3'h0;
      start_sync_q <= 3'h0;
    end else begin
      req_sync_q <= {req_sync_q[1:0], i_frame_req_pin};
      start_sync_q <= {start_sync_q[1:0], i_exposure_start_pin};
    end
  end

  // Rising edges are held until the next pixel enable; a new edge wins over the clear.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      req_evt_q <= 1'b0;
      start_evt_q <= 1'b0;
    end else begin
      req_evt_q <= (req_sync_q[1] & ~req_sync_q[2]) | (req_evt_q & ~pix_en);
      start_evt_q <= (start_sync_q[1] & ~start_sync_q[2]) | (start_evt_q & ~pix_en);
    end
  end

  // Exposure and overhead lengths in pixel periods; a count of zero acts as one.
  always_comb begin
    exp_len = (((exp_count_q == 16'h0000) ? 32'd0 : 32'(exp_count_q) - 32'd1) *
               32'(ROW_PERIOD)) + 32'd1 + 32'(EXP_OVH_FACTOR) * 32'(ovh_mult_q);
    ovh_len = 32'(OVH_MULT_FACTOR) * 32'(ovh_mult_q) + 32'(ovh_mult_q / 8'(OVH_MULT_DIV)) +
              32'(OVH_ROWS * ROW_PERIOD);
  end

  // Readout may accept a finished exposure when idle or on its very last pixel slot.
  assign last_pix = (rd_q == RD_READOUT) && (pix_q == 10'(ROW_PERIOD - 1)) &&
                    (burst_q == 16'(BURSTS - 1));
  assign rd_free = (rd_q == RD_IDLE) || last_pix;
  assign exp_end = exp_source_q ? req_evt_q : (ex_cnt_q == 32'd1);
  assign start_ovh = pix_en && rd_free &&
                     (((ex_q == EX_RUN) && exp_end) || (ex_q == EX_PEND));

  // Exposure engine, running independently of readout so the two overlap.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ex_q <= EX_IDLE;
      ex_cnt_q <= 32'd0;
    end else if (pix_en) begin
      unique case (ex_q)
        EX_IDLE: begin
          if (!exp_source_q && req_evt_q) begin
            ex_q <= EX_RUN;
            ex_cnt_q <= exp_len;
          end else if (exp_source_q && start_evt_q) begin
            ex_q <= EX_RUN;
          end
        end
        EX_RUN: begin
          if (exp_end) begin
            ex_q <= rd_free ? EX_IDLE : EX_PEND;
          end else if (!exp_source_q) begin
            ex_cnt_q <= ex_cnt_q - 32'd1;
          end
        end
        EX_PEND: begin
          if (rd_free) begin
            ex_q <= EX_IDLE;
          end
        end
        default: ex_q <= EX_IDLE;
      endcase
    end
  end

  // Readout engine: overhead, then row-pair bursts of 640 pixels plus one gap slot.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_q <= RD_IDLE;
      rd_cnt_q <= 32'd0;
      pix_q <= 10'h000;
      burst_q <= 16'h0000;
    end else if (pix_en) begin
      if (start_ovh) begin
        rd_q <= RD_OVERHEAD;
        rd_cnt_q <= ovh_len;
      end else begin
        unique case (rd_q)
          RD_IDLE: ;
          RD_OVERHEAD: begin
            if (rd_cnt_q <= 32'd1) begin
              rd_q <= RD_READOUT;
              pix_q <= 10'h000;
              burst_q <= 16'h0000;
            end else begin
              rd_cnt_q <= rd_cnt_q - 32'd1;
            end
          end
          RD_READOUT: begin
            if (pix_q == 10'(ROW_PERIOD - 1)) begin
              pix_q <= 10'h000;
              if (burst_q == 16'(BURSTS - 1)) begin
                rd_q <= RD_IDLE;
              end else begin
                burst_q <= burst_q + 16'h0001;
              end
            end else begin
              pix_q <= pix_q + 10'h001;
            end
          end
          default: rd_q <= RD_IDLE;
        endcase
      end
    end
  end

  // Status word assembled from the engines' state.
  always_comb begin
    status = '0;
    status.one9 = 1'b1;
    status.frame_valid = (rd_q == RD_READOUT);
    status.row_valid = (rd_q == RD_READOUT) && (pix_q < 10'(BURST_LEN));
    status.pixel_valid = status.row_valid;
    status.overhead = (rd_q == RD_OVERHEAD);
    status.integ_one = (ex_q == EX_RUN);
    status.integ_two = (ex_q == EX_RUN);
  end

  // Per-lane words: pixel or synthetic value while valid, training word otherwise.
  generate
    for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
      always_comb begin
        if (!status.pixel_valid) begin
          lane_words[l*WORD_W +: WORD_W] = align_q;
        end else if (synth_q) begin
          lane_words[l*WORD_W +: WORD_W] = 12'(burst_q + 16'(pix_q) + 16'(l));
        end else begin
          lane_words[l*WORD_W +: WORD_W] = i_pixel_data[l*WORD_W +: WORD_W];
        end
      end
      isrs_serializer u_lane (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_load(pix_en),
        .i_word(lane_words[l*WORD_W +: WORD_W]),
        .o_bit(o_data_lanes[l])
      );
    end
  endgenerate

  // Control lane carries only status words.
  isrs_serializer u_ctrl (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_load(pix_en),
    .i_word(status),
    .o_bit(o_control_lane)
  );

  // Debug pin selection, registered; unlisted codes drive low.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dbg1_q <= 1'b0;
      dbg2_q <= 1'b0;
    end else begin
      dbg1_q <= (dbg1_sel_q == DBG1_FRAME_VALID) ? status.frame_valid :
                (dbg1_sel_q == DBG1_OVERHEAD) ? status.overhead :
                (dbg1_sel_q == DBG1_INTEG_TWO) ? status.integ_two : 1'b0;
      dbg2_q <= (dbg2_sel_q == DBG2_ROW_VALID) ? status.row_valid :
                (dbg2_sel_q == DBG2_INTEG_ONE) ? status.integ_one :
                (dbg2_sel_q == DBG2_PIX_CLOCK) ? slow_clk : 1'b0;
    end
  end

  assign o_debug_pin_one = dbg1_q;
  assign o_debug_pin_two = dbg2_q;

  // Checks on the sequencing and the words handed to the serialisers.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_status_fixed: assert property ((status.zero_hi == 2'b00) && status.one9 &&
    !status.zero8 && (status.zero_mid == 2'b00)) else $error("status constant bits wrong");
  a_idle_word: assert property ((rd_q == RD_IDLE) && (ex_q == EX_IDLE) |->
    (status == 12'h200)) else $error("idle status word wrong");
  a_training_gap: assert property (pix_en && (rd_q == RD_READOUT) && (pix_q == 10'd640) |->
    (lane_words[WORD_W-1:0] == align_q) ##1 !o_debug_pin_two || (dbg2_sel_q != 3'h0))
    else $error("gap slot did not carry training word");
  a_pix_period: assert property (pix_en |=> !pix_en ##11 pix_en)
    else $error("pixel enable period not twelve");
  a_lsb_phase: assert property (pix_en |=> o_lvds_clk ##1 !o_lvds_clk)
    else $error("bit 0 not in forwarded clock high phase");
  a_overhead_len: assert property ((rd_q != RD_OVERHEAD) ##1 (rd_q == RD_OVERHEAD) |->
    (rd_cnt_q == $past(ovh_len))) else $error("overhead length wrong");
  a_exposure_len: assert property ((ex_q == EX_IDLE) ##1
    (ex_q == EX_RUN) && !exp_source_q |-> (ex_cnt_q == $past(exp_len)))
    else $error("exposure length wrong");
  a_frame_valid: assert property ((rd_q == RD_READOUT) |-> status.frame_valid &&
    (status.pixel_valid == (pix_q < 10'd640))) else $error("valid bits inconsistent");
  a_synth_value: assert property (status.pixel_valid && synth_q |->
    (lane_words[2*WORD_W +: WORD_W] == 12'(burst_q + 16'(pix_q) + 16'd2)))
    else $error("synthetic pixel wrong");
  a_debug_one: assert property ((dbg1_sel_q == 4'h2) ##1 (dbg1_sel_q == 4'h2) |->
    (o_debug_pin_one == $past(status.overhead))) else $error("debug pin one wrong");

  c_readout: cover property ((rd_q == RD_OVERHEAD) ##1 (rd_q == RD_READOUT));
  c_pending: cover property (ex_q == EX_PEND);
  c_external: cover property (exp_source_q && (ex_q == EX_RUN));
  c_synth: cover property (synth_q && status.pixel_valid);

endmodule

/* testbench/isrs_receiver.sv */
`timescale 1ns/10ps
// Receiver model: finds word boundaries on the idle control pattern and unpacks all lanes.
module isrs_receiver
  import isrs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [NUM_LANES-1:0] i_data_lanes,
  input wire logic i_control_lane,
  input wire logic i_lvds_clk,
  output logic o_locked,
  output logic o_word_stb,
  output logic o_capture,
  output logic o_clk_err,
  output isrs_status_t o_status,
  output logic [NUM_LANES*WORD_W-1:0] o_lanes
);
  logic [WORD_W-1:0] ctl_sh_d;
  logic [WORD_W-1:0] ctl_sh_q;
  logic [WORD_W-1:0] lane_sh_q [NUM_LANES];
  logic [3:0] bit_cnt_q;
  logic word_end;

  // Newest bit enters at the top, so the first bit sent lands at bit 0.
  assign ctl_sh_d = {i_control_lane, ctl_sh_q[WORD_W-1:1]};
  // Alignment needs the idle word; once locked a word ends every twelfth bit.
  assign word_end = o_locked ? (bit_cnt_q == 4'hb) : (ctl_sh_d == 12'h200);

  // Shift registers for the control lane and every data lane.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl_sh_q <= '0;
      for (int l = 0; l < NUM_LANES; l++) lane_sh_q[l] <= '0;
    end else begin
      ctl_sh_q <= ctl_sh_d;
      for (int l = 0; l < NUM_LANES; l++) lane_sh_q[l] <= {i_data_lanes[l], lane_sh_q[l][11:1]};
    end
  end

  // Word framing, capture decision and forwarded clock phase check.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_locked <= 1'b0;
      o_word_stb <= 1'b0;
      o_capture <= 1'b0;
      o_clk_err <= 1'b0;
      o_status <= '0;
      o_lanes <= '0;
      bit_cnt_q <= 4'h0;
    end else begin
      o_word_stb <= word_end;
      bit_cnt_q <= word_end ? 4'h0 : bit_cnt_q + 4'h1;
      if (word_end) begin
        o_locked <= 1'b1;
        o_status <= ctl_sh_d;
        // Only the three valid bits decide whether image data is taken.
        o_capture <= ctl_sh_d[0] & ctl_sh_d[1] & ctl_sh_d[2];
        for (int l = 0; l < NUM_LANES; l++) begin
          o_lanes[l*WORD_W +: WORD_W] <= {i_data_lanes[l], lane_sh_q[l][11:1]};
        end
      end
      // Even bits must come with the forwarded clock high.
      if (o_locked && (i_lvds_clk !== ~bit_cnt_q[0])) o_clk_err <= 1'b1;
    end
  end
endmodule

/* testbench/image_sensor_readout_sequencer_bench.sv */
`timescale 1ns/10ps
module image_sensor_readout_sequencer_bench;
  import isrs_pkg::*;
  localparam int BURSTS = 2;
  localparam int OVH_WORDS = OVH_ROWS * ROW_PERIOD;
  localparam int FRAME_WORDS = OVH_WORDS + BURSTS * ROW_PERIOD;
  localparam logic [11:0] TRAIN = 12'hfa5;
  typedef struct {logic [6:0] a; logic [15:0] rst; logic [15:0] w; logic [15:0] r;} isrs_row_t;
  logic clk, resetn, wr, rd, req, start, rvalid, ctl, lclk, d1, d2, lock, stb, cap, cerr;
  logic synth, done, prev_fv, prev_cap, prev_d2, score;
  logic [6:0] addr;
  logic [15:0] wdata, rdata;
  logic [11:0] exp_w;
  logic [NUM_LANES*WORD_W-1:0] pixels, rx;
  logic [NUM_LANES-1:0] lanes;
  isrs_status_t st;
  isrs_row_t rows [8];
  int mismatches, comparisons, n_ovh, n_int, n_fv, n_rv, n_pv, n_gap, widx, first_ovh;
  int last_fv, pix, row, c1, c2, k;

  isrs_readout #(.NUM_LINES(4), .NUM_SIDES(2)) u_dut (.i_clk(clk), .i_resetn(resetn),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_frame_req_pin(req), .i_exposure_start_pin(start),
    .i_pixel_data(pixels), .o_data_lanes(lanes), .o_control_lane(ctl), .o_lvds_clk(lclk),
    .o_debug_pin_one(d1), .o_debug_pin_two(d2));
  isrs_receiver u_rx (.i_clk(clk), .i_resetn(resetn), .i_data_lanes(lanes),
    .i_control_lane(ctl), .i_lvds_clk(lclk), .o_locked(lock), .o_word_stb(stb),
    .o_capture(cap), .o_clk_err(cerr), .o_status(st), .o_lanes(rx));

  // Clock at 125 MHz.
  always #4 clk = ~clk;

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [6:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read valid", {15'h0, rvalid}, 16'h0001);
    chk("read data", rdata, e);
  endtask

  task automatic pulse(input bit on_start);
    @(posedge clk);
    if (on_start) start <= 1'b1; else req <= 1'b1;
    repeat (3) @(posedge clk);
    start <= 1'b0;
    req <= 1'b0;
  endtask

  task automatic run_frame(input logic s);
    @(posedge clk);
    #1;
    {n_ovh, n_int, n_fv, n_rv, n_pv, n_gap, pix, row, c1, c2} = '0;
    {done, prev_fv, prev_cap} = '0;
    first_ovh = -1;
    synth = s;
    if (!s) pulse(1'b1);
    if (!s) repeat (96) @(posedge clk);
    pulse(1'b0);
    k = 0;
    while (!done && k < 40000) begin
      @(posedge clk);
      k++;
    end
    chk("frame end", {15'h0, done}, 16'h0001);
    chk("valid pixel words", 16'(n_pv), 16'(BURSTS * BURST_LEN));
    chk("row valid words", 16'(n_rv), 16'(BURSTS * BURST_LEN));
    chk("burst gaps", 16'(n_gap), 16'(BURSTS));
    chk("rows seen", 16'(row), 16'(BURSTS));
    chk("readout words", 16'(n_fv), 16'(BURSTS * ROW_PERIOD));
    chk("overhead words", 16'(n_ovh), 16'(OVH_WORDS));
    chk("frame words", 16'(last_fv - first_ovh + 1), 16'(FRAME_WORDS));
  endtask

  // Score each received word and count status bits and debug pin cycles.
  always @(posedge clk) begin
    c1 += d1;
    c2 += d2;
    if (stb) begin
      widx++;
      chk("status constants", {4'h0, st & 12'hf18}, 16'h0200);
      chk("integration pair", {15'h0, st.integ_two}, {15'h0, st.integ_one});
      // Lane words are scored only once the training word has been programmed.
      for (int l = 0; l < NUM_LANES && score; l++) begin
        exp_w = cap ? (synth ? 12'(row + pix + l) : 12'(12'h300 + l)) : TRAIN;
        chk("lane word", {4'h0, rx[l*WORD_W +: WORD_W]}, {4'h0, exp_w});
      end
      n_ovh += st.overhead;
      n_int += st.integ_one;
      n_fv += st.frame_valid;
      n_rv += st.row_valid;
      n_pv += cap;
      n_gap += st.frame_valid & ~st.pixel_valid;
      if (st.overhead && first_ovh < 0) first_ovh = widx;
      if (st.frame_valid) last_fv = widx;
      if (prev_fv && !st.frame_valid) done = 1'b1;
      if (cap) pix++;
      else if (prev_cap) begin
        row++;
        pix = 0;
      end
      prev_fv = st.frame_valid;
      prev_cap = cap;
    end
  end

  // Watchdog sized for two short frames plus register traffic.
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    $display("unexpected timeout: expected run end, seen none");
    conclude();
  end

  initial begin
    {clk, resetn, wr, rd, req, start, synth, done, prev_fv, prev_cap, prev_d2, score} = '0;
    {mismatches, comparisons, widx, last_fv} = '0;
    addr = '0;
    wdata = '0;
    for (int l = 0; l < NUM_LANES; l++) pixels[l*WORD_W +: WORD_W] = 12'(12'h300 + l);
    rows = '{'{REG_EXPOSURE_COUNT, 16'h0f00, 16'h0001, 16'h0001},
      '{REG_EXPOSURE_SOURCE, 16'h0000, 16'hfffe, 16'h0000},
      '{REG_OVERHEAD_MULT, 16'h0050, 16'hff00, 16'h0000},
      '{REG_SYNTH_IMAGE, 16'h0000, 16'hffff, 16'h0001},
      '{REG_ALIGNMENT_WORD, 16'h0000, 16'hffa5, 16'h0fa5},
      '{REG_DEBUG_ONE_SEL, 16'h0000, 16'hfff2, 16'h0002},
      '{REG_DEBUG_TWO_SEL, 16'h0000, 16'hfff3, 16'h0003},
      '{7'h7f, 16'h0000, 16'hffff, 16'h0000}};
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    // Reset value, masked write and read back of every register.
    foreach (rows[i]) begin
      reg_read(rows[i].a, rows[i].rst);
      reg_write(rows[i].a, rows[i].w);
      reg_read(rows[i].a, rows[i].r);
    end
    repeat (40) @(posedge clk);
    #1;
    score = 1'b1;
    chk("receiver lock", {15'h0, lock}, 16'h0001);
    chk("idle status", {4'h0, st}, 16'h0200);
    // Internal exposure with the synthetic image, debug pins on overhead and block one.
    run_frame(1'b1);
    chk("exposure words", 16'(n_int), 16'h0001);
    chk("debug one cycles", 16'(c1), 16'(PIX_DIV * n_ovh));
    chk("debug two cycles", 16'(c2), 16'(PIX_DIV * n_int));
    // External exposure with live pixels, debug pins on frame and row valid.
    reg_write(REG_EXPOSURE_SOURCE, 16'h0001);
    reg_write(REG_SYNTH_IMAGE, 16'h0000);
    reg_write(REG_DEBUG_ONE_SEL, 16'h0000);
    reg_write(REG_DEBUG_TWO_SEL, 16'h0000);
    run_frame(1'b0);
    chk("pin exposure span", {15'h0, n_int >= 7 && n_int <= 10}, 16'h0001);
    chk("debug one cycles", 16'(c1), 16'(PIX_DIV * n_fv));
    chk("debug two cycles", 16'(c2), 16'(PIX_DIV * n_rv));
    chk("clock phase", {15'h0, cerr}, 16'h0000);
    // Divided clock on debug two: ten rising edges in 120 cycles.
    reg_write(REG_DEBUG_TWO_SEL, 16'h0007);
    repeat (4) @(posedge clk);
    #1;
    prev_d2 = d2;
    k = 0;
    for (int i = 0; i < 120; i++) begin
      @(posedge clk);
      #1;
      if (d2 && !prev_d2) k++;
      prev_d2 = d2;
    end
    chk("divided clock edges", 16'(k), 16'h000a);
    // Reset in mid-run clears outputs and the alignment word register.
    score = 1'b0;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("outputs in reset", {10'h0, rvalid, d1, d2, lanes != 0, ctl, lclk}, 16'h0000);
    @(posedge clk);
    resetn <= 1'b1;
    reg_read(REG_ALIGNMENT_WORD, 16'h0000);
    conclude();
  end
endmodule
